// File: rtl/fcm_mux_ctrl.sv
/*
  Bus slave and channel control for a 1-of-4 two-wire bus multiplexer with interrupt combining.
  Assumes upstream clock/data pins arrive asynchronously and are oversampled by ref_clk;
  the analogue pass gates are outside and are steered by chan_select.
*/
// Overview of operation
// - at most one downstream channel connected, chosen by the control register
// - combined interrupt output is AND of the four channel interrupt inputs
// - channel interrupt inputs are active low; low means pending
// - reset clears registers and slave state, deselects every channel
// - address LSB 1 reads control register, 0 writes it
// - three strap inputs form the low address bits, up to eight devices
// - slave works from static clock up to 400 kHz
// - bit 2 low selects none; high enables channel given by bits 1:0
// - newly written selection connects only after a STOP condition
// - several bytes in one transfer keep only the last one
// - read returns pending interrupts in bits 7:4, channel 3 at bit 7
`timescale 1ns/100ps
module fcm_mux_ctrl #(
  parameter int NUM_CHAN = fcm_pkg::NUM_CHAN
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_strap_0,
  input  wire logic       addr_strap_1,
  input  wire logic       addr_strap_2,
  input  wire logic       chan0_irq_in_n,
  input  wire logic       chan1_irq_in_n,
  input  wire logic       chan2_irq_in_n,
  input  wire logic       chan3_irq_in_n,
  output logic            irq_out_n,
  output logic [3:0]      chan_select,
  output logic [2:0]      control_value
);
  if (NUM_CHAN != 4) begin : g_bad_chan
    $error("fcm_mux_ctrl: only four channels are supported");
  end
  if (fcm_pkg::CLK_HZ < 10 * fcm_pkg::SCL_MAX_HZ) begin : g_slow_clk
    $error("fcm_mux_ctrl: clock too slow to oversample");
  end

  // ==========================================================================
  // input synchronisation
  // ==========================================================================
  logic [8:0] raw_in;
  logic [8:0] sync_in;
  assign raw_in = {scl_in, sda_in, addr_strap_2, addr_strap_1, addr_strap_0,
                   chan3_irq_in_n, chan2_irq_in_n, chan1_irq_in_n, chan0_irq_in_n};

  fcm_sync #(.WIDTH(9), .RESET_VALUE(9'h1FF)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  wire       scl_s    = sync_in[8];
  wire       sda_s    = sync_in[7];
  wire [2:0] strap_s  = sync_in[6:4];
  wire [3:0] irq_n_s  = sync_in[3:0];

  // ==========================================================================
  // bus condition detection
  // ==========================================================================
  logic scl_d;
  logic sda_d;
  wire  scl_rise   = scl_s & ~scl_d;
  wire  scl_fall   = ~scl_s & scl_d;
  wire  start_seen = scl_s & scl_d & sda_d & ~sda_s;
  wire  stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // ==========================================================================
  // slave state machine
  // ==========================================================================
  fcm_pkg::fcm_state_t state;
  fcm_pkg::fcm_state_t next_state;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic [2:0] ctrl_reg;
  logic       ctrl_dirty;
  logic [7:0] next_shift;
  logic [2:0] next_bit_cnt;
  logic [2:0] next_ctrl_reg;
  logic       next_ctrl_dirty;
  logic       next_sda_oe;

  wire [7:0] rx_byte   = {shift[6:0], sda_s};
  wire       addr_hit  = rx_byte[7:4] == fcm_pkg::ADDR_FIXED && rx_byte[3:1] == strap_s;
  wire [7:0] read_byte = {~irq_n_s, 1'b0, ctrl_reg};
  wire       byte_done = scl_rise & (bit_cnt == 3'h7);

  function automatic logic [3:0] fcm_decode(input logic [2:0] ctrl);
    fcm_decode = ctrl[fcm_pkg::CTRL_EN_POS] ?
      (4'h1 << {ctrl[fcm_pkg::CTRL_SEL_HI_POS], ctrl[fcm_pkg::CTRL_SEL_LO_POS]}) : 4'h0;
  endfunction : fcm_decode

  always_comb begin
    next_state      = state;
    next_shift      = shift;
    next_bit_cnt    = bit_cnt;
    next_ctrl_reg   = ctrl_reg;
    next_ctrl_dirty = ctrl_dirty;
    next_sda_oe     = sda_oe;
    if (start_seen) begin
      next_state   = fcm_pkg::FCM_ADDR;
      next_bit_cnt = 3'h0;
      next_sda_oe  = 1'b0;
    end else if (stop_seen) begin
      next_state      = fcm_pkg::FCM_IDLE;
      next_sda_oe     = 1'b0;
      next_ctrl_dirty = 1'b0;
    end else begin
      unique case (state)
        fcm_pkg::FCM_IDLE: begin
          next_sda_oe = 1'b0;
        end
        fcm_pkg::FCM_ADDR: begin
          if (scl_rise) begin
            next_shift   = rx_byte;
            next_bit_cnt = bit_cnt + 3'h1;
          end
          if (byte_done) begin
            next_state = addr_hit ? fcm_pkg::FCM_ADDR_ACK : fcm_pkg::FCM_IDLE;
          end
        end
        fcm_pkg::FCM_ADDR_ACK: begin
          if (scl_fall && !sda_oe) begin
            next_sda_oe = 1'b1;
          end else if (scl_fall && sda_oe) begin
            next_bit_cnt = 3'h0;
            next_shift   = read_byte;
            next_sda_oe  = shift[0] ? ~read_byte[7] : 1'b0;
            next_state   = shift[0] ? fcm_pkg::FCM_READ : fcm_pkg::FCM_WRITE;
          end
        end
        fcm_pkg::FCM_WRITE: begin
          if (scl_rise) begin
            next_shift   = rx_byte;
            next_bit_cnt = bit_cnt + 3'h1;
          end
          if (byte_done) begin
            next_ctrl_reg   = rx_byte[2:0];
            next_ctrl_dirty = 1'b1;
            next_state      = fcm_pkg::FCM_WRITE_ACK;
          end
        end
        fcm_pkg::FCM_WRITE_ACK: begin
          if (scl_fall && !sda_oe) begin
            next_sda_oe = 1'b1;
          end else if (scl_fall && sda_oe) begin
            next_sda_oe  = 1'b0;
            next_bit_cnt = 3'h0;
            next_state   = fcm_pkg::FCM_WRITE;
          end
        end
        fcm_pkg::FCM_READ: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 3'h1;
          end
          if (scl_fall) begin
            next_shift  = {shift[6:0], 1'b0};
            next_sda_oe = (bit_cnt == 3'h0) ? 1'b0 : ~shift[6];
            if (bit_cnt == 3'h0) begin
              next_state = fcm_pkg::FCM_READ_ACK;
            end
          end
        end
        fcm_pkg::FCM_READ_ACK: begin
          // master nack ends the read; ack reloads the byte at the clock fall
          if (scl_rise && sda_s) begin
            next_state = fcm_pkg::FCM_IDLE;
          end else if (scl_fall) begin
            next_bit_cnt = 3'h0;
            next_shift   = read_byte;
            next_sda_oe  = ~read_byte[7];
            next_state   = fcm_pkg::FCM_READ;
          end
        end
        default: next_state = fcm_pkg::FCM_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state      <= fcm_pkg::FCM_IDLE;
      shift      <= 8'h00;
      bit_cnt    <= 3'h0;
      ctrl_reg   <= fcm_pkg::CTRL_RESET;
      ctrl_dirty <= 1'b0;
      sda_oe     <= 1'b0;
    end else begin
      state      <= next_state;
      shift      <= next_shift;
      bit_cnt    <= next_bit_cnt;
      ctrl_reg   <= next_ctrl_reg;
      ctrl_dirty <= next_ctrl_dirty;
      sda_oe     <= next_sda_oe;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chan_select   <= fcm_pkg::SEL_RESET;
      control_value <= fcm_pkg::CTRL_RESET;
      irq_out_n     <= 1'b1;
      sda_out       <= 1'b0;
    end else begin
      if (stop_seen && ctrl_dirty) begin
        chan_select <= fcm_decode(ctrl_reg);
      end
      control_value <= ctrl_reg;
      irq_out_n     <= &irq_n_s;
      sda_out       <= 1'b0;
    end
  end
endmodule : fcm_mux_ctrl

// File: rtl/fcm_pkg.sv
/*
  Constants for the four-channel two-wire bus multiplexer control logic.
  Assumes a single system clock domain; the bus pins are sampled, not used as clocks.
*/
package fcm_pkg;
  // ==========================================================================
  // address and control byte layout
  // ==========================================================================
  localparam logic [3:0] ADDR_FIXED      = 4'hE;
  localparam int         ADDR_STRAP_W    = 3;
  localparam int         CTRL_EN_POS     = 2;
  localparam int         CTRL_SEL_HI_POS = 1;
  localparam int         CTRL_SEL_LO_POS = 0;
  localparam int         CTRL_IRQ_LSB    = 4;
  localparam logic [2:0] CTRL_RESET      = 3'h0;
  localparam logic [3:0] SEL_RESET       = 4'h0;
  localparam int         NUM_CHAN        = 4;
  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int         CLK_HZ          = 50_000_000;
  localparam int         SCL_MAX_HZ      = 400_000;
  localparam int         SYNC_STAGES     = 2;
  // ==========================================================================
  // slave states
  // ==========================================================================
  typedef enum logic [2:0] {
    FCM_IDLE,
    FCM_ADDR,
    FCM_ADDR_ACK,
    FCM_WRITE,
    FCM_WRITE_ACK,
    FCM_READ,
    FCM_READ_ACK
  } fcm_state_t;
endpackage : fcm_pkg

// File: rtl/fcm_sync.sv
/*
  Two-flip-flop synchroniser for a bundle of asynchronous levels.
  Assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/100ps
module fcm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_bad_width
    $error("fcm_sync: WIDTH must be positive");
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1   <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : fcm_sync

// File: verif/fcm_bus_master.sv
/* upstream two-wire master model
   assumes a pull-up resolves sda_line; calls start on a falling ref edge */
`timescale 1ns/100ps
module fcm_bus_master #(
  parameter time Q = 640ns
) (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // period 4*Q stays under the top rate
  task automatic start_cond();
    sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start_cond
  task automatic stop_cond();
    sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask : stop_cond
  // msb first, ninth bit is acknowledge; first byte is the address
  task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] r, output logic s_ack);
    logic b;
    for (int i = 9; i >= 0; i--) begin
      if (i > 0) sda_drv = (i == 1) ? m_ack : d[i-2];
      if (i == 0) break;
      #Q scl = 1'b1;
      #Q b = sda_line;
      if (i > 1) r[i-2] = b;
      s_ack = ~b;
      #Q scl = 1'b0;
      #Q;
    end
  endtask : xfer
endmodule : fcm_bus_master

// File: verif/fcm_mux_ctrl_assertions.sv
/* port checker for fcm_mux_ctrl
   assumes bind onto every instance of fcm_mux_ctrl */
`timescale 1ns/100ps
module fcm_mux_ctrl_assertions (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_oe,
  input wire logic       chan0_irq_in_n,
  input wire logic       chan1_irq_in_n,
  input wire logic       chan2_irq_in_n,
  input wire logic       chan3_irq_in_n,
  input wire logic       irq_out_n,
  input wire logic [3:0] chan_select,
  input wire logic [2:0] control_value
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic all_hi = &{chan3_irq_in_n, chan2_irq_in_n, chan1_irq_in_n, chan0_irq_in_n};
  sequence s_start; scl_in && $fell(sda_in); endsequence
  sequence s_bus_high; $past(scl_in, 6) && scl_in && sda_in; endsequence
  property p_onehot; $onehot0(chan_select); endproperty
  property p_irq_hi; all_hi [*7] |-> irq_out_n; endproperty
  property p_irq_lo; !all_hi [*7] |-> !irq_out_n; endproperty
  property p_sel_stop; $changed(chan_select) |-> s_bus_high; endproperty
  property p_sel_dec; $changed(chan_select) |-> chan_select == (control_value[2] ? 4'h1 << control_value[1:0] : 4'h0);
  endproperty
  property p_oe_low; $rose(sda_oe) |-> !scl_in; endproperty
  property p_oe_high; scl_in && $past(scl_in, 4) |-> $stable(sda_oe); endproperty
  property p_rst; disable iff (1'b0) rst ##1 rst |-> chan_select == 4'h0 && !sda_oe && irq_out_n; endproperty
  property p_start; s_start |-> !sda_oe [*8]; endproperty
  a_onehot: assert property (p_onehot) else $error("several channels selected");
  a_irq_hi: assert property (p_irq_hi) else $error("irq out low with inputs idle");
  a_irq_lo: assert property (p_irq_lo) else $error("irq out high with input pending");
  a_sel_stop: assert property (p_sel_stop) else $error("selection changed without stop");
  a_sel_dec: assert property (p_sel_dec) else $error("selection not decoded from control");
  a_oe_low: assert property (p_oe_low) else $error("data driven while clock high");
  a_oe_high: assert property (p_oe_high) else $error("data changed while clock high");
  a_rst: assert property (p_rst) else $error("reset values wrong");
  a_start: assert property (p_start) else $error("data driven after start");
endmodule : fcm_mux_ctrl_assertions
bind fcm_mux_ctrl fcm_mux_ctrl_assertions u_chk (.ref_clk, .rst, .scl_in, .sda_in, .sda_oe, .chan0_irq_in_n,
  .chan1_irq_in_n, .chan2_irq_in_n, .chan3_irq_in_n, .irq_out_n, .chan_select, .control_value);

// File: verif/tb_fcm_mux_ctrl.sv
/* testbench for fcm_mux_ctrl driven through the master model
   assumes the checker is bound by its own file */
`timescale 1ns/100ps
module tb_fcm_mux_ctrl;
  logic       ref_clk = 1'b0;
  logic       rst     = 1'b1;
  logic       scl;
  logic       m_sda;
  logic       sda_out;
  logic       sda_oe;
  logic [2:0] strap   = 3'h5;
  logic [3:0] irq_n   = 4'hF;
  logic       irq_out_n;
  logic [3:0] chan_select;
  logic [2:0] control_value;
  int         fail_count = 0;
  int         checked    = 0;
  int         cycles     = 0;
  wire logic  sda_line = m_sda & ~(sda_oe & ~sda_out);
  always #10 ref_clk = ~ref_clk;
  fcm_bus_master m (.scl(scl), .sda_drv(m_sda), .sda_line(sda_line));
  fcm_mux_ctrl dut (.ref_clk, .rst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
    .addr_strap_0(strap[0]), .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
    .chan0_irq_in_n(irq_n[0]), .chan1_irq_in_n(irq_n[1]), .chan2_irq_in_n(irq_n[2]),
    .chan3_irq_in_n(irq_n[3]), .irq_out_n, .chan_select, .control_value);
  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, output logic ok);
    logic [7:0] r;
    logic       k;
    m.start_cond();
    m.xfer(a, 1'b1, r, ok);
    if (ok) m.xfer(d0, 1'b1, r, k);
    if (ok) m.xfer(d1, 1'b1, r, k);
  endtask : wr
  task automatic finish_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      finish_test();
    end
  end
  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    logic       ok;
    logic [7:0] r;
    logic [3:0] e;
    e = 4'h0;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("chan_select", 8'h00, {4'h0, chan_select});
    chk("control_value", 8'h00, {5'h00, control_value});
    chk("sda_out", 8'h00, {7'h00, sda_out});
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      irq_n = i[3:0];
      repeat (8) @(negedge ref_clk);
      chk("irq_out_n", {7'h00, &irq_n}, {7'h00, irq_out_n});
    end
    irq_n = 4'hF;
    $display("test irq done");
    for (int c = 0; c < 8; c++) begin
      wr({4'hE, strap, 1'b0}, ~c[7:0], c[7:0], ok);
      chk("ack", 8'h01, {7'h00, ok});
      chk("held", {4'h0, e}, {4'h0, chan_select});
      m.stop_cond();
      repeat (8) @(negedge ref_clk);
      e = c[2] ? 4'h1 << c[1:0] : 4'h0;
      chk("chan_select", {4'h0, e}, {4'h0, chan_select});
    end
    $display("test select done");
    for (int j = 0; j < 2; j++) begin
      wr(j ? 8'hC0 ^ {4'hE, strap, 1'b0} : {4'hE, 3'h4, 1'b0}, 8'h04, 8'h04, ok);
      m.stop_cond();
      chk("nack", 8'h00, {7'h00, ok});
      chk("control_value", 8'h07, {5'h00, control_value});
    end
    $display("test address done");
    strap = 3'h2;
    irq_n = 4'h9;
    repeat (8) @(negedge ref_clk);
    m.start_cond();
    m.xfer({4'hE, 3'h2, 1'b1}, 1'b1, r, ok);
    chk("ack", 8'h01, {7'h00, ok});
    m.xfer(8'hFF, 1'b1, r, ok);
    m.stop_cond();
    chk("read", 8'h67, r);
    chk("chan_select", 8'h08, {4'h0, chan_select});
    $display("test read done");
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("chan_select", 8'h00, {4'h0, chan_select});
    chk("control_value", 8'h00, {5'h00, control_value});
    chk("sda_oe", 8'h00, {7'h00, sda_oe});
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    m.start_cond();
    m.xfer({4'hE, 3'h2, 1'b1}, 1'b1, r, ok);
    chk("ack", 8'h01, {7'h00, ok});
    m.xfer(8'hFF, 1'b0, r, ok);
    chk("read", 8'h60, r);
    m.xfer(8'hFF, 1'b1, r, ok);
    m.stop_cond();
    chk("read again", 8'h60, r);
    chk("chan_select", 8'h00, {4'h0, chan_select});
    $display("test reset again done");
    finish_test();
  end
endmodule : tb_fcm_mux_ctrl
